// *** logic/pw_guard.sv ***
// Password write guard for a PMBus command set, reached over Avalon-MM.
// Software stages a command code, clears the payload length and appends payload bytes, then writes GO;
// the guard answers ACK or NACK and applies the write if allowed. The nonvolatile
// password image arrives as a port that is loaded once after reset release.
`timescale 1ns/10ps
module pw_guard
  import pw_guard_pkg::*;
#(
  parameter logic [255:0] WRITABLE_DEFAULT = {256{1'b1}}
) (
  input wire logic sys_clk, // 10 MHz system clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall until answer is ready
  input wire logic [47:0] nv_password, // Nonvolatile password image
  output logic [47:0] store_password, // Password to commit to flash
  output logic store_strobe, // One-cycle store pulse
  output logic security_on, // Security armed by a non-erased password, also while unlocked
  output logic unlock_locked // Lockout after wrong password
);
  typedef enum logic [1:0] {S_LOAD = 2'b00, S_IDLE = 2'b01, S_ANS = 2'b11} state_t;

  state_t state;
  logic [7:0] cmd_code;
  logic [5:0] pay_len;
  logic [7:0] pay [PW_BYTES];
  logic [255:0] prot_mask;
  logic [255:0] writable;
  logic [47:0] password;
  logic unlocked;
  logic last_ack;
  logic last_nack;
  logic [31:0] rd_q;

  av_req_t req;
  verdict_t verdict;
  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata};

  // Payload as one word, first byte received in the top byte
  wire logic [47:0] pay_word = {pay[0], pay[1], pay[2], pay[3], pay[4], pay[5]};
  wire logic len_ok = (pay_len == 6'(PW_BYTES));
  wire logic is_setup = (cmd_code == CMD_PASSWORD_SETUP);
  wire logic is_unlock = (cmd_code == CMD_UNLOCK);
  wire logic is_mask = (cmd_code == CMD_WRITE_PROTECT_MASK);
  // Index bit 255-code equals byte code/8, bit 7-(code mod 8) counting byte 0 at the top
  wire logic [7:0] mask_idx = 8'(8'hff - cmd_code);
  // Codes with no write operation never become protected
  wire logic code_prot = prot_mask[mask_idx] & writable[mask_idx];
  wire logic enforce = security_on & ~unlocked;
  // A write is blocked when its mask bit and writable bit are set and security is enforced
  wire logic blocked = enforce & code_prot;
  wire logic pw_match = (pay_word == password);
  wire logic [7:0] status_byte = unlock_locked ? ST_LOCKED :
                                 (enforce ? ST_ON : ST_OFF);
  wire logic go_hit = req.write & (req.address == OFS_GO) & (state == S_IDLE);
  wire logic [4:0] mask_byte = 5'(req.writedata[12:8]);

  // Verdict for a staged command
  always_comb begin
    verdict.ack = 1'b0;
    verdict.nack = 1'b0;
    verdict.status_code = {40'h0000000000, status_byte};
    if (is_unlock) begin
      if (!len_ok || unlock_locked || !pw_match) verdict.nack = 1'b1;
      else verdict.ack = 1'b1;
    end else if (is_setup) begin
      // The setup is itself protected unless security was lifted first
      if (!len_ok || enforce) verdict.nack = 1'b1;
      else verdict.ack = 1'b1;
    end else if (is_mask) begin
      if (enforce) verdict.nack = 1'b1;
      else verdict.ack = 1'b1;
    end else if (blocked) begin
      verdict.nack = 1'b1;
    end else begin
      verdict.ack = 1'b1;
    end
  end

  // Read mux; the password itself is never visible here
  always_comb begin
    unique case (req.address)
      OFS_CMD: rd_q = {24'h000000, cmd_code};
      OFS_LEN: rd_q = {26'h0000000, pay_len};
      OFS_RESULT: rd_q = {30'h00000000, last_nack, last_ack};
      OFS_RDATA: rd_q = verdict.status_code[31:0];
      OFS_STATUS: rd_q = {29'h00000000, unlock_locked, unlocked, security_on};
      OFS_WRITABLE: rd_q = {31'h00000000, writable[mask_idx]};
      default: rd_q = RD_UNMAPPED;
    endcase
  end

  // Waitrequest holds every access one cycle so read data come from a flop
  logic answered;
  assign avs_waitrequest = (req.read | req.write) & ~answered;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      answered <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      answered <= (req.read | req.write) & ~answered;
      avs_readdata <= req.read ? rd_q : 32'h00000000;
    end
  end

  // Staging registers written by software
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_code <= 8'h00;
      pay_len <= LEN_RESET;
      for (int i = 0; i < PW_BYTES; i++) pay[i] <= 8'h00;
    end else if (req.write && answered) begin
      if (req.address == OFS_CMD && avs_byteenable[0]) cmd_code <= req.writedata[7:0];
      if (req.address == OFS_LEN) pay_len <= LEN_RESET;
      // Data word: byte in [7:0]; appends in order at index pay_len
      if (req.address == OFS_DATA && pay_len < 6'(PW_BYTES)) begin
        pay[pay_len[2:0]] <= req.writedata[7:0];
        pay_len <= 6'(pay_len + 6'h01);
      end else if (req.address == OFS_DATA) begin
        pay_len <= 6'(PW_BYTES + 1); // Overlong payload stays wrong
      end
    end
  end

  // Security state, mask and password
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= S_LOAD;
      password <= PW_ERASED;
      security_on <= 1'b0;
      unlocked <= 1'b0;
      unlock_locked <= 1'b0;
      prot_mask <= '0;
      writable <= '0;
      last_ack <= 1'b0;
      last_nack <= 1'b0;
      store_strobe <= 1'b0;
      store_password <= PW_ERASED;
    end else begin
      store_strobe <= 1'b0;
      unique case (state)
        S_LOAD: begin
          // Strap-like capture of the stored password after reset release
          password <= nv_password;
          security_on <= (nv_password != PW_ERASED);
          writable <= WRITABLE_DEFAULT;
          state <= S_IDLE;
        end
        S_IDLE: begin
          if (go_hit && answered) begin
            last_ack <= verdict.ack;
            last_nack <= verdict.nack;
            state <= S_ANS;
            if (verdict.ack && is_unlock) unlocked <= 1'b1;
            if (!verdict.ack && is_unlock && len_ok) unlock_locked <= 1'b1;
            if (verdict.ack && is_setup) begin
              password <= pay_word;
              security_on <= (pay_word != PW_ERASED);
              unlocked <= 1'b0;
            end
            if (verdict.ack && is_mask) begin
              // Mask byte n at lane [12:8], value in [7:0]; byte 0 is codes 00..07
              prot_mask[8'(8'd255 - {mask_byte, 3'b000}) -: 8] <= req.writedata[7:0];
            end
          end else if (req.write && answered && req.address == OFS_STORE) begin
            store_password <= password;
            store_strobe <= 1'b1;
          end else if (req.write && answered && req.address == OFS_WRITABLE) begin
            writable[mask_idx] <= req.writedata[0];
          end
        end
        S_ANS: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule : pw_guard

// *** logic/pw_guard_pkg.sv ***
// Package for the PMBus password write guard: command codes, sizes, status codes,
// register map of the Avalon-MM slave and the carrier structs.
// Assumes one 10 MHz system clock; no timing constants are needed.
package pw_guard_pkg;
  localparam logic [7:0] CMD_PASSWORD_SETUP = 8'hf1;
  localparam logic [7:0] CMD_UNLOCK = 8'hf2;
  localparam logic [7:0] CMD_WRITE_PROTECT_MASK = 8'hf4;
  localparam int PW_BYTES = 6;
  localparam int MASK_BYTES = 32;
  localparam logic [47:0] PW_ERASED = 48'hffffffffffff;
  localparam logic [7:0] ST_OFF = 8'h00;
  localparam logic [7:0] ST_ON = 8'h01;
  localparam logic [7:0] ST_LOCKED = 8'h02;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_LEN = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_GO = 8'h0c;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_NVPW_LO = 8'h1c;
  localparam logic [7:0] OFS_NVPW_HI = 8'h20;
  localparam logic [7:0] OFS_STORE = 8'h24;
  localparam logic [7:0] OFS_WRITABLE = 8'h28;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
  localparam logic [5:0] LEN_RESET = 6'h00;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } av_req_t;

  typedef struct packed {
    logic ack;
    logic nack;
    logic [47:0] status_code;
  } verdict_t;
endpackage : pw_guard_pkg

// *** tb/pw_guard_nv_model.sv ***
// Nonvolatile password store beside the guard.
// Assumes a commit is a single store pulse.
`timescale 1ns/10ps
module pw_guard_nv_model #(
  parameter logic [47:0] INIT_PW = 48'h0a0b0c0d0e0f
) (
  input wire logic sys_clk, // Clock
  input wire logic [47:0] store_password, // Password to keep
  input wire logic store_strobe, // Commit pulse
  output logic [47:0] nv_password // Image read at power-up
);
  // Commit only on the pulse, so staged passwords never reach flash
  initial nv_password = INIT_PW;
  always @(posedge sys_clk) begin
    if (store_strobe === 1'b1) nv_password <= store_password;
  end
endmodule : pw_guard_nv_model

// *** tb/pw_guard_properties.sv ***
// Port checker for the password guard.
// Assumes one wait state per access and GO effects within two cycles.
`timescale 1ns/10ps
module pw_guard_properties
  import pw_guard_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic avs_waitrequest, // Stall
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic [47:0] nv_password, // Stored image
  input wire logic store_strobe, // Store pulse
  input wire logic security_on, // Armed
  input wire logic unlock_locked // Lockout
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Taken accesses; a GO may settle state one cycle late
  wire req = avs_read | avs_write;
  wire go = avs_write & !avs_waitrequest & (avs_address == OFS_GO);
  wire st_rd = avs_read & !avs_waitrequest & (avs_address == OFS_RDATA);
  sequence go_seen;
    $past(go) || $past(go, 2);
  endsequence
  AST_WAIT_STATE: assert property (req && !$past(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state missing");
  AST_IDLE: assert property (!req |-> !avs_waitrequest)
    else $error("stall without request");
  AST_CODE: assert property (st_rd |-> avs_readdata[31:8] == 24'h000000 && avs_readdata[7:0] <= ST_LOCKED)
    else $error("status code carries other data");
  AST_LOCK_CODE: assert property (st_rd && unlock_locked |-> avs_readdata[7:0] == ST_LOCKED)
    else $error("lockout not reported");
  AST_LOCK_HOLD: assert property (unlock_locked |=> unlock_locked)
    else $error("lockout cleared");
  AST_LOCK_CAUSE: assert property ($rose(unlock_locked) |-> go_seen)
    else $error("lockout without command");
  AST_SEC_CAUSE: assert property ($changed(security_on) && !$past(rst, 3) |-> go_seen)
    else $error("security changed without command");
  AST_POWER_UP: assert property ($fell(rst) |-> !unlock_locked ##2 security_on == (nv_password != PW_ERASED))
    else $error("power-up state wrong");
  AST_STORE: assert property ($rose(store_strobe) |-> $past(avs_write && !avs_waitrequest && avs_address == OFS_STORE) ##1 !store_strobe)
    else $error("store pulse wrong");
endmodule : pw_guard_properties
bind pw_guard pw_guard_properties i_pw_guard_properties (.sys_clk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_waitrequest, .avs_readdata, .nv_password, .store_strobe, .security_on,
  .unlock_locked);

// *** tb/pw_guard_tb_top.sv ***
// Bench for the password guard: Avalon tasks and command sequences.
// Assumes the nv model starts with a non-erased password.
`timescale 1ns/10ps
module pw_guard_tb_top;
  import pw_guard_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, store_strobe, security_on, unlock_locked;
  logic [47:0] nv_password, store_password;
  int num_errors = 0;
  int n_tests = 0;
  localparam logic [47:0] OLD_PW = 48'h0a0b0c0d0e0f;
  localparam logic [47:0] NEW_PW = 48'h112233445566;
  always #50 sys_clk = ~sys_clk;
  pw_guard i_pw_guard (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .nv_password, .store_password,
    .store_strobe, .security_on, .unlock_locked);
  pw_guard_nv_model #(.INIT_PW(OLD_PW)) i_pw_guard_nv_model (.sys_clk, .store_password,
    .store_strobe, .nv_password);
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One access, held until waitrequest is seen low at an edge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // No cycle limit here: only the watchdog may end a wait
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  // Stage a command with n payload bytes, run it, compare {nack,ack}
  task automatic op(input logic [7:0] cmd, input int n, input logic [47:0] pw,
                    input logic [31:0] go, input logic [1:0] exp);
    logic [31:0] q;
    acc(1'b1, OFS_CMD, {24'h000000, cmd}, q);
    acc(1'b1, OFS_LEN, 32'h00000000, q);
    for (int i = 0; i < n; i++) acc(1'b1, OFS_DATA, {24'h000000, pw[47-8*i -: 8]}, q);
    acc(1'b1, OFS_GO, go, q);
    acc(1'b0, OFS_RESULT, 32'h00000000, q);
    chk("result", {46'h0, exp}, {16'h0, q});
  endtask : op
  // Host judges security by the last status byte only
  task automatic status(input logic [7:0] exp);
    logic [31:0] q;
    acc(1'b0, OFS_RDATA, 32'h00000000, q);
    chk("status", {40'h0, exp}, {40'h0, q[7:0]});
  endtask : status
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // Watchdog, well past the few hundred cycles the sequence needs
  initial begin
    #300000;
    num_errors++;
    end_sim;
  end
  initial begin
    logic [31:0] q;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    status(ST_ON);
    op(CMD_WRITE_PROTECT_MASK, 0, 48'h0, 32'h00000280, 2'h2);
    op(CMD_UNLOCK, 5, OLD_PW, 32'h00000000, 2'h2);
    status(ST_ON);
    op(CMD_UNLOCK, 6, OLD_PW, 32'h00000000, 2'h1);
    status(ST_OFF);
    acc(1'b0, OFS_STATUS, 32'h00000000, q);
    chk("status_reg", 48'h3, {16'h0, q});
    op(CMD_WRITE_PROTECT_MASK, 0, 48'h0, 32'h00000280, 2'h1);
    op(CMD_PASSWORD_SETUP, 6, NEW_PW, 32'h00000000, 2'h1);
    status(ST_ON);
    chk("security_on", 48'h1, {47'h0, security_on});
    op(CMD_PASSWORD_SETUP, 6, OLD_PW, 32'h00000000, 2'h2);
    op(8'h10, 0, 48'h0, 32'h00000000, 2'h2);
    op(8'h11, 0, 48'h0, 32'h00000000, 2'h1);
    // A code without a write operation is never protected, mask bit or not
    acc(1'b1, OFS_CMD, 32'h00000010, q);
    acc(1'b1, OFS_WRITABLE, 32'h00000000, q);
    acc(1'b0, OFS_WRITABLE, 32'h00000000, q);
    chk("writable", 48'h0, {16'h0, q});
    op(8'h10, 0, 48'h0, 32'h00000000, 2'h1);
    acc(1'b1, OFS_STORE, 32'h00000000, q);
    repeat (2) @(posedge sys_clk);
    chk("stored", NEW_PW, nv_password);
    op(CMD_UNLOCK, 6, OLD_PW, 32'h00000000, 2'h2);
    status(ST_LOCKED);
    chk("unlock_locked", 48'h1, {47'h0, unlock_locked});
    op(CMD_UNLOCK, 6, NEW_PW, 32'h00000000, 2'h2);
    // Power cycle: lockout gone, stored password arms security again
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("lock_cleared", 48'h0, {47'h0, unlock_locked});
    status(ST_ON);
    op(CMD_UNLOCK, 6, NEW_PW, 32'h00000000, 2'h1);
    status(ST_OFF);
    acc(1'b0, 8'h3c, 32'h00000000, q);
    chk("unmapped", {16'h0, RD_UNMAPPED}, {16'h0, q});
    end_sim;
  end
endmodule : pw_guard_tb_top
